// file: rtl/rmc_map.svh
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH
`define RMC_CLK_NS 10
`define RMC_BAUD 300
`define RMC_BIT_CYC (1_000_000_000 / (`RMC_CLK_NS * `RMC_BAUD))
`define RMC_TICK_NS 1_000_000
`define RMC_TICK_CYC (`RMC_TICK_NS / `RMC_CLK_NS)
`define RMC_REVERT_MIN 5
`define RMC_REVERT_TICKS (`RMC_REVERT_MIN * 60 * 1000)
`define RMC_ADDR_CTRL 8'h00
`define RMC_ADDR_STATUS 8'h04
`define RMC_ADDR_MON_LO 8'h08
`define RMC_ADDR_MON_HI 8'h0c
`define RMC_ADDR_TRIP_LO 8'h10
`define RMC_ADDR_TRIP_HI 8'h14
`define RMC_CTRL_LINK_EN 0
`define RMC_CTRL_CLEAR 1
`define RMC_CTRL_RESET 2'h1
`define RMC_CK_POINT 16
`define RMC_FRAME_BITS 4'h9
`define RMC_CH_CR 7'h0d
`endif

// file: rtl/rmc_pkg.sv
`default_nettype none
package rmc_pkg;
  typedef enum logic [2:0] {
    RMC_MON = 3'b001,
    RMC_LOC = 3'b010,
    RMC_SER = 3'b100
  } rmc_mode_e;
  typedef logic [63:0] rmc_map_t;
endpackage
`default_nettype wire

// file: rtl/rmc_top.sv
// Implementation choices: the placing of the registers and the strobed register port.
`include "rmc_map.svh"
`default_nettype none
module rmc_top #(
  parameter int BIT_CYC = `RMC_BIT_CYC,
  parameter int TICK_CYC = `RMC_TICK_CYC,
  parameter int REVERT_TICKS = `RMC_REVERT_TICKS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sel_fault,
  input wire logic step_btn,
  input wire logic clear_btn,
  input wire logic [3:0] unit_addr,
  input wire logic [5:0] point_num,
  input wire logic point_valid,
  input wire logic trip_pt_valid,
  input wire logic trip_in,
  input wire logic ck_fail,
  input wire logic rx_line,
  output var logic tx_line_q,
  output var logic [3:0] disp_hi_q,
  output var logic [3:0] disp_lo_q,
  output var logic led_trip_q,
  output var logic led_mon_q,
  output var logic alarm_q,
  output var logic monitor_en_q,
  output var rmc_pkg::rmc_mode_e mode_q,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output var logic [31:0] rd_data_q
);
  import rmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [5:0] rmc_next(input rmc_map_t map, input logic [5:0] cur);
    logic [5:0] r;
    r = 6'h0;
    for (int i = 63; i >= 1; i--) begin
      if (map[i] && (6'(i) > cur)) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [6:0] rmc_msg(input logic [3:0] idx, input logic [6:0] id,
                                         input logic m, input logic t);
    logic [6:0] c;
    c = `RMC_CH_CR;
    unique case (idx)
      4'h0, 4'h1, 4'h2: c = 7'h2a;
      4'h3: c = id;
      4'h4: c = 7'h20;
      4'h5: c = m ? 7'h4d : (t ? 7'h54 : 7'h4e);
      4'h6: c = (m && t) ? 7'h20 : `RMC_CH_CR;
      4'h7: c = 7'h54;
      default: c = `RMC_CH_CR;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and panel edges

  logic [1:0] ctrl_q;
  logic soft_clr_q;
  logic step_prev_q;
  logic clr_prev_q;
  logic sel_loc_flt_q;
  logic loc_mon_q;
  logic loc_flt_q;
  logic selected_q;
  logic ck_err_q;
  rmc_map_t mon_map_q;
  rmc_map_t trip_map_q;
  logic [5:0] cur_pt_q;
  logic rx_busy_q;
  logic tx_busy_q;
  logic cmd_quit;
  logic cmd_clear;
  logic cmd_sel;
  logic rx_start;

  wire link_busy = rx_busy_q | tx_busy_q;
  wire link_en = ctrl_q[`RMC_CTRL_LINK_EN];
  wire step_ok = step_btn & ~step_prev_q & ~link_busy;
  wire clr_ok = (clear_btn & ~clr_prev_q & ~link_busy) | soft_clr_q;
  wire [6:0] id_char = (unit_addr < 4'ha) ? 7'h30 + {3'h0, unit_addr}
                                          : 7'h37 + {3'h0, unit_addr};
  wire rmc_map_t sel_map = sel_fault ? trip_map_q : mon_map_q;
  wire sel_same = (sel_fault == loc_flt_q);
  wire mon_act = (mode_q != RMC_SER) & ~(step_btn & ~step_prev_q) & ~trip_in;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      step_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_btn;
      clr_prev_q <= clear_btn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= `RMC_CTRL_RESET;
      soft_clr_q <= 1'b0;
    end else begin
      soft_clr_q <= wr_en && (addr == `RMC_ADDR_CTRL) && wr_data[`RMC_CTRL_CLEAR];
      if (wr_en && (addr == `RMC_ADDR_CTRL)) begin
        ctrl_q <= {1'b0, wr_data[`RMC_CTRL_LINK_EN]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_data_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        `RMC_ADDR_CTRL: rd_data_q <= {30'h0, ctrl_q};
        `RMC_ADDR_STATUS: rd_data_q <= {25'h0, selected_q, ck_err_q, loc_flt_q, loc_mon_q, mode_q};
        `RMC_ADDR_MON_LO: rd_data_q <= mon_map_q[31:0];
        `RMC_ADDR_MON_HI: rd_data_q <= mon_map_q[63:32];
        `RMC_ADDR_TRIP_LO: rd_data_q <= trip_map_q[31:0];
        `RMC_ADDR_TRIP_HI: rd_data_q <= trip_map_q[63:32];
        default: rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control with reversion timer

  logic [31:0] pre_q;
  logic [31:0] tmr_q;
  wire tmr_done = (tmr_q >= 32'(REVERT_TICKS));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= RMC_MON;
      loc_mon_q <= 1'b0;
      loc_flt_q <= 1'b0;
    end else if (trip_in || clr_ok) begin
      mode_q <= RMC_MON;
      loc_mon_q <= 1'b0;
      loc_flt_q <= 1'b0;
    end else begin
      unique case (mode_q)
        RMC_MON: begin
          if (step_ok) begin
            mode_q <= RMC_LOC;
            loc_flt_q <= sel_fault;
            loc_mon_q <= ~sel_fault;
          end else if (rx_start && link_en) begin
            mode_q <= RMC_SER;
          end
        end
        RMC_LOC: begin
          // Link starts are dropped here, so the panel owns the unit
          if (tmr_done || (step_ok && !sel_same)) begin
            mode_q <= RMC_MON;
            loc_mon_q <= 1'b0;
            loc_flt_q <= 1'b0;
          end
        end
        RMC_SER: begin
          if (tmr_done || cmd_quit) begin
            mode_q <= RMC_MON;
          end
        end
      endcase
    end
  end

  // Prescaler restarts on every entry so each mode gets a full interval
  always_ff @(posedge clk_sys) begin
    if (reset || mode_q == RMC_MON) begin
      pre_q <= 32'h0000_0000;
      tmr_q <= 32'h0000_0000;
    end else if (pre_q >= 32'(TICK_CYC - 1)) begin
      pre_q <= 32'h0000_0000;
      tmr_q <= tmr_q + 32'h0000_0001;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored data, display and indicators

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mon_map_q <= 64'h0000_0000_0000_0000;
      trip_map_q <= 64'h0000_0000_0000_0000;
    end else if (clr_ok || cmd_clear) begin
      mon_map_q <= 64'h0000_0000_0000_0000;
      trip_map_q <= 64'h0000_0000_0000_0000;
    end else begin
      if (mon_act && point_valid) begin
        mon_map_q[point_num] <= 1'b1;
      end
      if (ck_err_q) begin
        mon_map_q[`RMC_CK_POINT] <= 1'b1;
      end
      if (trip_pt_valid) begin
        trip_map_q[point_num] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ck_err_q <= 1'b0;
    end else if (ck_fail) begin
      ck_err_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || trip_in || clr_ok) begin
      cur_pt_q <= 6'h0;
    end else if (mode_q == RMC_LOC && tmr_done) begin
      cur_pt_q <= 6'h0;
    end else if (step_ok && (mode_q == RMC_MON || (mode_q == RMC_LOC && sel_same))) begin
      cur_pt_q <= rmc_next(sel_map, cur_pt_q);
    end else if (step_ok && mode_q == RMC_LOC) begin
      cur_pt_q <= 6'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      disp_hi_q <= 4'h0;
      disp_lo_q <= 4'h0;
      led_trip_q <= 1'b0;
      led_mon_q <= 1'b0;
      alarm_q <= 1'b0;
      monitor_en_q <= 1'b0;
    end else begin
      if (ck_err_q) begin
        disp_hi_q <= 4'hc;
        disp_lo_q <= 4'h5;
      end else begin
        disp_hi_q <= 4'(cur_pt_q / 6'd10);
        disp_lo_q <= 4'(cur_pt_q % 6'd10);
      end
      led_trip_q <= |trip_map_q;
      led_mon_q <= |mon_map_q;
      alarm_q <= (|mon_map_q) | ck_err_q;
      monitor_en_q <= mon_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver: light on is a space, so an off line reads idle

  logic [31:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_sh_q;
  logic [34:0] buf_q;
  logic [2:0] len_q;
  logic rx_char;
  wire rx_bit = ~rx_line;
  wire local_on = loc_mon_q | loc_flt_q;
  assign rx_start = ~rx_busy_q & rx_line & ~local_on;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 32'h0000_0000;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_char <= 1'b0;
    end else begin
      rx_char <= 1'b0;
      if (rx_start && link_en) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= 32'(BIT_CYC / 2);
        rx_idx_q <= 4'h0;
      end else if (rx_busy_q) begin
        if (rx_cnt_q != 32'h0000_0000) begin
          rx_cnt_q <= rx_cnt_q - 32'h0000_0001;
        end else begin
          rx_cnt_q <= 32'(BIT_CYC - 1);
          rx_idx_q <= rx_idx_q + 4'h1;
          if (rx_idx_q == 4'h0 && rx_bit) begin
            rx_busy_q <= 1'b0; // False start glitch
          end else if (rx_idx_q == `RMC_FRAME_BITS) begin
            rx_busy_q <= 1'b0;
            // Bit 0 holds a stale bit from the last frame, so parity skips it
            rx_char <= rx_bit && (^rx_sh_q[8:1]);
          end else if (rx_idx_q != 4'h0) begin
            rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
          end
        end
      end
    end
  end

  // Last five characters; a carriage return closes the command
  wire [6:0] rx_ch = rx_sh_q[7:1];
  wire is_cr = rx_char && (rx_ch == `RMC_CH_CR);
  always_comb begin
    cmd_quit = 1'b0;
    cmd_clear = 1'b0;
    cmd_sel = 1'b0;
    if (is_cr && mode_q == RMC_SER) begin
      cmd_quit = (len_q == 3'h4) && (buf_q[27:0] == {7'h51, 7'h55, 7'h49, 7'h54});
      cmd_sel = (len_q == 3'h4) && (buf_q[27:0] == {7'h2a, 7'h2a, 7'h2a, id_char});
      cmd_clear = selected_q && (len_q == 3'h5) &&
                  (buf_q == {7'h43, 7'h4c, 7'h45, 7'h41, 7'h52});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      buf_q <= 35'h0_0000_0000;
      len_q <= 3'h0;
    end else if (rx_char) begin
      if (rx_ch == `RMC_CH_CR) begin
        len_q <= 3'h0;
      end else begin
        buf_q <= {buf_q[27:0], rx_ch};
        len_q <= (len_q == 3'h7) ? 3'h7 : len_q + 3'h1; // Long lines never match
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || cmd_quit || cmd_clear || mode_q != RMC_SER) begin
      selected_q <= 1'b0;
    end else if (cmd_sel) begin
      selected_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial transmitter for the selection answer

  logic [31:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_chr_q;
  logic [9:0] tx_sh_q;
  logic ans_m_q;
  logic ans_t_q;
  wire [6:0] tx_c = rmc_msg(tx_chr_q, id_char, ans_m_q, ans_t_q);
  wire tx_last = (tx_c == `RMC_CH_CR);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 32'h0000_0000;
      tx_bit_q <= 4'h0;
      tx_chr_q <= 4'h0;
      tx_sh_q <= 10'h000;
      ans_m_q <= 1'b0;
      ans_t_q <= 1'b0;
      tx_line_q <= 1'b0;
    end else if (!tx_busy_q) begin
      tx_line_q <= 1'b0;
      if (cmd_sel && link_en) begin
        tx_busy_q <= 1'b1;
        tx_chr_q <= 4'h0;
        tx_bit_q <= 4'h0;
        tx_cnt_q <= 32'h0000_0000;
        tx_sh_q <= {1'b1, ~^7'h2a, 7'h2a, 1'b0};
        ans_m_q <= |mon_map_q;
        ans_t_q <= |trip_map_q;
      end
    end else if (tx_cnt_q != 32'h0000_0000) begin
      tx_cnt_q <= tx_cnt_q - 32'h0000_0001;
    end else begin
      tx_cnt_q <= 32'(BIT_CYC - 1);
      tx_line_q <= ~tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      if (tx_bit_q == `RMC_FRAME_BITS) begin
        tx_bit_q <= 4'h0;
        if (tx_last) begin
          tx_busy_q <= 1'b0;
        end else begin
          tx_chr_q <= tx_chr_q + 4'h1;
          tx_sh_q <= {1'b1, ~^rmc_msg(tx_chr_q + 4'h1, id_char, ans_m_q, ans_t_q),
                      rmc_msg(tx_chr_q + 4'h1, id_char, ans_m_q, ans_t_q), 1'b0};
        end
      end else begin
        tx_bit_q <= tx_bit_q + 4'h1;
      end
    end
  end

endmodule // rmc_top
`default_nettype wire

// file: tb/relay_monitor_mode_control_bench.sv
`default_nettype none
module relay_monitor_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rmc_pkg::*;
  localparam int BIT_CYC = 20;
  localparam int TICK_CYC = 100;
  localparam int REVERT_TICKS = 100;
  localparam int REV = TICK_CYC * REVERT_TICKS + 2 * TICK_CYC + 10;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sel_fault = 1'b0, step_btn = 1'b0, clear_btn = 1'b0, point_valid = 1'b0;
  logic trip_pt_valid = 1'b0, trip_in = 1'b0, ck_fail = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0] unit_addr = 4'hb;
  logic [5:0] point_num = 6'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wr_data = 32'h0;
  logic rx_line, tx_line_q, led_trip_q, led_mon_q, alarm_q, monitor_en_q;
  logic [3:0] disp_hi_q, disp_lo_q;
  logic [31:0] rd_data_q;
  rmc_mode_e mode_q;
  int error_cnt = 0;
  int n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  rmc_top #(.BIT_CYC(BIT_CYC), .TICK_CYC(TICK_CYC), .REVERT_TICKS(REVERT_TICKS)) dut (
    .clk_sys, .reset, .sel_fault, .step_btn, .clear_btn, .unit_addr, .point_num,
    .point_valid, .trip_pt_valid, .trip_in, .ck_fail, .rx_line, .tx_line_q, .disp_hi_q,
    .disp_lo_q, .led_trip_q, .led_mon_q, .alarm_q, .monitor_en_q, .mode_q, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data_q
  );
  rmc_term #(.BIT_CYC(BIT_CYC)) term (.clk_sys, .tx_line_q, .rx_line);
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data_q, e, "register read");
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic step();
    step_btn <= 1'b1;
    cyc(3);
    step_btn <= 1'b0;
    cyc(5);
  endtask
  task automatic pt(input logic [5:0] n, input logic trip);
    point_num <= n;
    point_valid <= !trip;
    trip_pt_valid <= trip;
    @(posedge clk_sys);
    point_valid <= 1'b0;
    trip_pt_valid <= 1'b0;
  endtask
  task automatic wait_mode(input rmc_mode_e m);
    for (int i = 0; i < REV && mode_q !== m; i++) @(posedge clk_sys);
  endtask
  task automatic reply(input string s);
    for (int i = 0; i < 4000 && !(term.got.size() > 0 && term.got[$] == 7'h0d); i++) cyc(1);
    chk(term.got.size(), s.len(), "reply length");
    foreach (term.got[i]) chk(term.got[i], s[i], "reply char");
    term.got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h1);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
  endtask
  task automatic t_local();
    pt(6'd9, 1'b0);
    pt(6'd31, 1'b0);
    cyc(3);
    chk(led_mon_q, 1'b1, "monitor indicator");
    step();
    chk(mode_q, RMC_LOC, "local entry");
    chk({disp_hi_q, disp_lo_q}, 8'h09, "first point");
    rd(8'h04, 32'ha);
    term.send_str("A", 0);
    chk(mode_q, RMC_LOC, "link refused");
    pt(6'd20, 1'b0);
    step();
    chk({disp_hi_q, disp_lo_q}, 8'h20, "next point");
    sel_fault <= 1'b1;
    step();
    chk(mode_q, RMC_MON, "local exit");
    chk({disp_hi_q, disp_lo_q}, 8'h00, "start marker");
    rd(8'h08, 32'h8010_0200);
  endtask
  task automatic t_revert();
    sel_fault <= 1'b0;
    step();
    cyc(REVERT_TICKS * TICK_CYC - 2 * TICK_CYC);
    chk(mode_q, RMC_LOC, "early reversion");
    wait_mode(RMC_MON);
    chk(mode_q, RMC_MON, "local reversion");
    step();
    clear_btn <= 1'b1;
    cyc(3);
    clear_btn <= 1'b0;
    cyc(3);
    chk(mode_q, RMC_MON, "panel clear");
    rd(8'h08, 32'h0);
  endtask
  task automatic t_serial();
    pt(6'd12, 1'b0);
    fork
      term.send_str("***B\r", 0);
      begin cyc(300); step(); end
    join
    chk(mode_q, RMC_SER, "serial entry");
    chk(monitor_en_q, 1'b0, "monitoring held");
    reply("***B M\r");
    term.send_str("QUIT\r", 40);
    cyc(5);
    chk(mode_q, RMC_MON, "quit");
    rd(8'h08, 32'h1000);
    term.send_str("***5\r", 0);
    chk(mode_q, RMC_SER, "any traffic");
    term.send_str("CLEAR\r", 0);
    cyc(300);
    chk(term.got.size(), 0, "unaddressed silent");
    chk(mode_q, RMC_SER, "clear keeps others");
    rd(8'h08, 32'h1000);
    wait_mode(RMC_MON);
    chk(mode_q, RMC_MON, "serial reversion");
    term.send_str("***B\r", 0);
    reply("***B M\r");
    term.send_str("CLEAR\r", 0);
    cyc(5);
    chk(mode_q, RMC_SER, "remote clear");
    rd(8'h08, 32'h0);
    pt(6'd6, 1'b1);
    trip_in <= 1'b1;
    cyc(1);
    trip_in <= 1'b0;
    cyc(3);
    chk(mode_q, RMC_MON, "trip exit");
    rd(8'h10, 32'h40);
  endtask
  task automatic t_cksum();
    ck_fail <= 1'b1;
    cyc(3);
    chk({disp_hi_q, disp_lo_q, alarm_q}, 9'h18b, "checksum display");
    rd(8'h04, 32'h21);
    rd(8'h08, 32'h0001_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Whole run is near 27.5k cycles; the watchdog leaves ample margin
  initial begin
    cyc(95000);
    error_cnt++;
    end_of_test();
  end
  initial begin
    cyc(5);
    reset <= 1'b0;
    cyc(1);
    t_regs();
    t_local();
    t_revert();
    t_serial();
    t_cksum();
    end_of_test();
  end
endmodule // relay_monitor_mode_control_bench
`default_nettype wire

// file: tb/rmc_chk.sv
`default_nettype none
module rmc_chk #(
  parameter int TICK_CYC = 4,
  parameter int REVERT_TICKS = 10
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic step_btn,
  input wire logic clear_btn,
  input wire logic trip_in,
  input wire logic trip_pt_valid,
  input wire logic ck_fail,
  input wire logic rx_line,
  input wire logic wr_en,
  input wire logic tx_line_q,
  input wire logic [3:0] disp_hi_q,
  input wire logic [3:0] disp_lo_q,
  input wire logic led_trip_q,
  input wire logic alarm_q,
  input wire logic monitor_en_q,
  input wire rmc_pkg::rmc_mode_e mode_q
);
  import rmc_pkg::*;
  // Slack covers prescaler phase and entry latency
  localparam int LIM = REVERT_TICKS * TICK_CYC + 2 * TICK_CYC + 8;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  rmc_mode_e mode_p_q;
  int cnt_q;
  always_ff @(posedge clk_sys) begin
    mode_p_q <= mode_q;
  end
  always_ff @(posedge clk_sys) begin
    if (reset || mode_q == RMC_MON || mode_q != mode_p_q) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_step_mon;
    (mode_q == RMC_MON && !step_btn && !rx_line && !tx_line_q)
      ##1 (step_btn && !trip_in && !clear_btn && mode_q == RMC_MON);
  endsequence
  sequence s_ser_held;
    mode_q == RMC_SER ##1 mode_q == RMC_SER;
  endsequence
  a_step_local:
    assert property (s_step_mon |-> ##[1:3] mode_q == RMC_LOC)
    else $error("step press did not enter local display");
  a_mode_onehot:
    assert property ($onehot(mode_q))
    else $error("mode is not one-hot");
  a_local_no_serial:
    assert property (mode_q == RMC_LOC |=> mode_q != RMC_SER)
    else $error("link taken while local display");
  a_local_tx_off:
    assert property (mode_q == RMC_LOC |-> !tx_line_q)
    else $error("transmitter on in local display");
  a_step_gap:
    assert property ($rose(step_btn) |-> ##[1:2] !monitor_en_q)
    else $error("monitoring kept on step pass");
  a_serial_quiet:
    assert property (s_ser_held |-> !monitor_en_q)
    else $error("monitoring active in serial mode");
  a_trip_mon:
    assert property (trip_in |-> ##[1:2] mode_q == RMC_MON)
    else $error("trip did not force monitor mode");
  a_ck_disp:
    assert property (ck_fail |-> ##[1:2] (disp_hi_q == 4'hc && disp_lo_q == 4'h5 && alarm_q))
    else $error("checksum failure not shown");
  a_trip_led:
    assert property ((trip_pt_valid && !clear_btn && !wr_en) |-> ##[1:3] led_trip_q)
    else $error("trip indicator not lit");
  a_revert_bound:
    assert property (cnt_q <= LIM)
    else $error("mode outlived reversion time");
endmodule // rmc_chk
bind rmc_top rmc_chk #(.TICK_CYC(TICK_CYC), .REVERT_TICKS(REVERT_TICKS)) u_chk (
  .clk_sys, .reset, .step_btn, .clear_btn, .trip_in, .trip_pt_valid, .ck_fail, .rx_line,
  .wr_en, .tx_line_q, .disp_hi_q, .disp_lo_q, .led_trip_q, .alarm_q, .monitor_en_q, .mode_q
);
`default_nettype wire

// file: tb/rmc_term.sv
`default_nettype none
module rmc_term #(
  parameter int BIT_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic tx_line_q,
  output var logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] got[$];
  initial rx_line = 1'b0;
  task automatic send_bit(input logic b);
    rx_line <= b;
    repeat (BIT_CYC) @(posedge clk_sys);
  endtask
  // Gap lets a slow operator be modelled between characters
  task automatic send_str(input string s, input int gap);
    byte c;
    foreach (s[i]) begin
      c = s[i];
      send_bit(1'b1);
      for (int k = 0; k < 7; k++) send_bit(~c[k]);
      send_bit(^c[6:0]);
      send_bit(1'b0);
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bad frames are kept as NUL so the reply compare catches them
  initial begin
    logic [8:0] f;
    forever begin
      @(posedge clk_sys iff tx_line_q);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int k = 0; k < 9; k++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        f[k] = ~tx_line_q;
      end
      got.push_back((^f[7:0] && f[8]) ? f[6:0] : 7'h00);
    end
  end
endmodule // rmc_term
`default_nettype wire
